// [hsc_pkg.sv]
// Purpose: Shared constants and carriers for the halt standby controller.
// Assumes: One 250 MHz clock; wait counts are in CPU clock enables.
// Notes: The clock-enable divider supplies the CPU clock rate.
package hsc_pkg;

    // ==========================================================
    // Wait counts after release and divider ratio
    // ==========================================================
    localparam logic [3:0] HSC_WAIT_VECTOR = 4'h8;
    localparam logic [3:0] HSC_WAIT_RESUME = 4'h2;
    localparam logic [3:0] HSC_WAIT_ZERO = 4'h0;
    localparam logic [3:0] HSC_DIV_RATIO = 4'h4;
    localparam logic [3:0] HSC_DIV_ZERO = 4'h0;

    // ==========================================================
    // States
    // ==========================================================
    typedef enum logic [1:0] {
        HSC_RUN = 2'b00,
        HSC_HALT = 2'b01,
        HSC_WAIT = 2'b10
    } hsc_state_t;

    // Oscillator status bundle.
    typedef struct packed {
        logic fast_internal_osc_run;
        logic main_crystal_run;
        logic slow_internal_osc_run;
        logic sub_osc_run;
    } hsc_osc_t;

    // Oscillator hold value after reset: only the sub clock is held on.
    localparam hsc_osc_t HSC_OSC_HOLD_RST = 4'h1;

    // Reset sources bundle.
    typedef struct packed {
        logic pin;
        logic watchdog_reset_source;
        logic power_on_clear_source;
        logic low_voltage_detect_source;
    } hsc_rst_src_t;

    // Unit gating outputs.
    typedef struct packed {
        logic cpu_clk_en;
        logic flash_en;
        logic regulator_low;
        logic watchdog_clk_en;
        logic adc_en;
        logic sub_clk_hold;
    } hsc_gate_t;

    // Gate values after reset: CPU, flash, watchdog and sub clock hold on.
    localparam hsc_gate_t HSC_GATE_RST = 6'h35;

endpackage

// [hsc_divider.sv]
// Purpose: Divider producing a one-cycle enable at the CPU clock rate.
// Assumes: Ratio is at least one.
// Notes: Used to time the post-release wait in CPU clocks.
module hsc_divider
    import hsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Enable
    output logic tick_out
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        if (cnt_q == HSC_DIV_RATIO - 4'h1) begin
            cnt_d = HSC_DIV_ZERO;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 4'h1;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= HSC_DIV_ZERO;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;
endmodule

// [hsc_top.sv]
// Purpose: HALT standby control while the CPU runs from the subsystem clock.
// Assumes: Interrupt pending already has masks applied by the interrupt logic.
// Notes: Reset sources are combined here into a CPU reset request.
module hsc_top
    import hsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // CPU side
    input wire logic halt_exec_in,
    input wire logic irq_unmasked_pending_in,
    input wire logic irq_accept_en_in,
    // Clock and option status
    input wire hsc_osc_t osc_in,
    input wire logic slow_osc_sw_stoppable_in,
    input wire logic periph_clk_run_in,
    input wire hsc_rst_src_t rst_src_in,
    // Status and control
    output logic halted_out,
    output logic vector_go_out,
    output logic resume_go_out,
    output logic cpu_reset_out,
    output hsc_gate_t gate_out,
    output hsc_osc_t osc_hold_out
);
    // ==========================================================
    // Clock enable
    // ==========================================================
    logic tick;

    hsc_divider u_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_out(tick)
    );

    // ==========================================================
    // Sequencer state
    // ==========================================================
    hsc_state_t state_q;
    hsc_state_t state_d;
    logic [3:0] wait_q;
    logic [3:0] wait_d;
    logic vec_q;
    logic vec_d;
    logic vgo_q;
    logic vgo_d;
    logic rgo_q;
    logic rgo_d;
    logic crst_q;
    logic crst_d;
    hsc_osc_t hold_q;
    hsc_osc_t hold_d;
    hsc_gate_t gate_q;
    hsc_gate_t gate_d;
    hsc_osc_t osc_out_q;
    hsc_osc_t osc_out_d;
    logic halted_q;
    logic halted_d;
    logic halt_next;
    logic halt_take;
    logic any_rst;

    assign any_rst = |rst_src_in;
    // A halt instruction is taken only from RUN and never against a reset source.
    assign halt_take = (state_q == HSC_RUN) && halt_exec_in && !any_rst;

    always_comb begin
        state_d = state_q;
        wait_d = wait_q;
        vec_d = vec_q;
        vgo_d = 1'b0;
        rgo_d = 1'b0;
        if (any_rst) begin
            state_d = HSC_RUN;
            wait_d = HSC_WAIT_ZERO;
            vec_d = 1'b0;
        end else begin
            unique case (state_q)
                HSC_RUN: begin
                    if (halt_exec_in) begin
                        state_d = HSC_HALT;
                    end
                end
                HSC_HALT: begin
                    if (irq_unmasked_pending_in) begin
                        state_d = HSC_WAIT;
                        vec_d = irq_accept_en_in;
                        // The extra clock comes from divider phase alignment.
                        wait_d = irq_accept_en_in ? HSC_WAIT_VECTOR
                                                  : HSC_WAIT_RESUME;
                    end
                end
                HSC_WAIT: begin
                    if (tick) begin
                        if (wait_q == 4'h1) begin
                            state_d = HSC_RUN;
                            wait_d = HSC_WAIT_ZERO;
                            vgo_d = vec_q;
                            rgo_d = !vec_q;
                        end else begin
                            wait_d = wait_q - 4'h1;
                        end
                    end
                end
                default: begin
                    state_d = HSC_RUN;
                end
            endcase
        end
    end

    // ==========================================================
    // Reset request
    // ==========================================================
    // Registered so that a short glitch on a source reaches the CPU as a full cycle.
    always_comb begin
        crst_d = any_rst;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            crst_q <= 1'b1;
        end else begin
            crst_q <= crst_d;
        end
    end

    // ==========================================================
    // Entry snapshot
    // ==========================================================
    // Loaded only on the halt edge, so a clock that changes while halted
    // cannot alter what the standby period keeps.
    always_comb begin
        hold_d = hold_q;
        if (halt_take) begin
            hold_d = osc_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_q <= '0;
        end else begin
            hold_q <= hold_d;
        end
    end

    // ==========================================================
    // Sequencer registers
    // ==========================================================
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= HSC_RUN;
            wait_q <= HSC_WAIT_ZERO;
            vec_q <= 1'b0;
            vgo_q <= 1'b0;
            rgo_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= wait_d;
            vec_q <= vec_d;
            vgo_q <= vgo_d;
            rgo_q <= rgo_d;
        end
    end

    // ==========================================================
    // Unit gating and output stage
    // ==========================================================
    // Gates other than adc_en are computed from the next state so they switch on the same
    // edge as halted_out and no unit sees a stale enable.
    always_comb begin
        halt_next = (state_d != HSC_RUN);
        gate_d.cpu_clk_en = !halt_next;
        gate_d.flash_en = !halt_next;
        gate_d.regulator_low = halt_next && !hold_d.fast_internal_osc_run;
        gate_d.watchdog_clk_en = !(halt_next && slow_osc_sw_stoppable_in);
        gate_d.adc_en = periph_clk_run_in;
        gate_d.sub_clk_hold = halt_next;
        halted_d = halt_next;
        osc_out_d = hold_d;
        osc_out_d.sub_osc_run = hold_d.sub_osc_run | halt_next;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            halted_q <= 1'b0;
            gate_q <= HSC_GATE_RST;
            osc_out_q <= HSC_OSC_HOLD_RST;
        end else begin
            halted_q <= halted_d;
            gate_q <= gate_d;
            osc_out_q <= osc_out_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign halted_out = halted_q;
    assign vector_go_out = vgo_q;
    assign resume_go_out = rgo_q;
    assign cpu_reset_out = crst_q;
    assign gate_out = gate_q;
    assign osc_hold_out = osc_out_q;
endmodule

// [hsc_top_properties.sv]
// Purpose: Port checker for hsc_top.
// Assumes: One clock domain.
// Notes: Wake windows allow for the divider phase.
module hsc_top_checker
    import hsc_pkg::*;
(
    // Inputs
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic halt_exec_in,
    input wire logic irq_unmasked_pending_in,
    input wire logic irq_accept_en_in,
    input wire logic slow_osc_sw_stoppable_in,
    input wire logic periph_clk_run_in,
    input wire hsc_rst_src_t rst_src_in,
    // Outputs
    input wire logic halted_out,
    input wire logic vector_go_out,
    input wire logic resume_go_out,
    input wire logic cpu_reset_out,
    input wire hsc_gate_t gate_out,
    input wire hsc_osc_t osc_hold_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence vec_wake_s;
        halted_out && $rose(irq_unmasked_pending_in) && irq_accept_en_in;
    endsequence
    sequence plain_wake_s;
        halted_out && $rose(irq_unmasked_pending_in) && !irq_accept_en_in;
    endsequence
    halt_entry_a: assert property (
        halt_exec_in && !halted_out && rst_src_in == '0 |-> ##[1:2] halted_out) else $error("no halt");
    cpu_gate_a: assert property (
        halted_out |-> !gate_out.cpu_clk_en && !gate_out.flash_en) else $error("cpu gate");
    osc_hold_a: assert property (
        halted_out && $past(halted_out) |-> $stable(osc_hold_out)) else $error("hold state");
    sub_run_a: assert property (
        halted_out |-> gate_out.sub_clk_hold && osc_hold_out.sub_osc_run) else $error("sub clock");
    reg_low_a: assert property (
        halted_out && $past(halted_out)
        |-> gate_out.regulator_low == !osc_hold_out.fast_internal_osc_run) else $error("regulator");
    wdt_gate_a: assert property (
        halted_out && $past(halted_out) && $stable(slow_osc_sw_stoppable_in)
        |-> gate_out.watchdog_clk_en == !slow_osc_sw_stoppable_in) else $error("watchdog");
    adc_gate_a: assert property (
        !periph_clk_run_in && !$past(periph_clk_run_in) |-> !gate_out.adc_en) else $error("adc");
    vec_wait_a: assert property (
        vec_wake_s |-> ##[26:40] vector_go_out) else $error("vector wait");
    plain_wait_a: assert property (
        plain_wake_s |-> ##[4:16] resume_go_out) else $error("resume wait");
    reset_src_a: assert property (
        rst_src_in != '0 |=> cpu_reset_out && !halted_out) else $error("reset source");
endmodule
bind hsc_top hsc_top_checker u_hsc_top_checker (.*);

// [hsc_irq_model.sv]
// Purpose: Interrupt source model facing hsc_top.
// Assumes: A request stays pending until serviced.
// Notes: Either go pulse clears it.
module hsc_irq_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Request control
    input wire logic raise_in,
    input wire logic go_in,
    // Pending request
    output logic pending_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pending_out <= 1'h0;
        end else begin
            pending_out <= (pending_out | raise_in) & ~go_in;
        end
    end
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for hsc_top.
// Assumes: Inputs change at the falling edge.
// Notes: Wake waits are judged as cycle windows.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hsc_pkg::*;
    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic halt_exec_in = 1'h0;
    logic irq_accept_en_in = 1'h0;
    logic slow_osc_sw_stoppable_in = 1'h0;
    logic periph_clk_run_in = 1'h1;
    logic raise = 1'h0;
    logic irq_unmasked_pending_in, halted_out, vector_go_out, resume_go_out, cpu_reset_out;
    hsc_osc_t osc_in = 4'h0;
    hsc_osc_t osc_hold_out;
    hsc_rst_src_t rst_src_in = 4'h0;
    hsc_gate_t gate_out;
    int fail_count = 0;
    int total_checks = 0;
    always #2 clk_in = ~clk_in;
    hsc_top u_hsc_top (.clk_in(clk_in), .rst_in(rst_in), .halt_exec_in(halt_exec_in),
        .irq_unmasked_pending_in(irq_unmasked_pending_in), .irq_accept_en_in(irq_accept_en_in),
        .osc_in(osc_in), .slow_osc_sw_stoppable_in(slow_osc_sw_stoppable_in),
        .periph_clk_run_in(periph_clk_run_in), .rst_src_in(rst_src_in),
        .halted_out(halted_out), .vector_go_out(vector_go_out), .resume_go_out(resume_go_out),
        .cpu_reset_out(cpu_reset_out), .gate_out(gate_out), .osc_hold_out(osc_hold_out));
    hsc_irq_model u_hsc_irq_model (.clk_in(clk_in), .rst_in(rst_in), .raise_in(raise),
        .go_in(vector_go_out | resume_go_out), .pending_out(irq_unmasked_pending_in));
    task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic halt_entry(input hsc_osc_t o, input logic s);
        osc_in = o;
        slow_osc_sw_stoppable_in = s;
        halt_exec_in = 1'h1;
        @(negedge clk_in);
        halt_exec_in = 1'h0;
        repeat (2) @(negedge clk_in);
        check("halted", halted_out, 4'h1);
        check("cpu_flash", {gate_out.cpu_clk_en, gate_out.flash_en}, 4'h0);
        check("hold", osc_hold_out, o | 4'h1);
        check("sub_hold", gate_out.sub_clk_hold, 4'h1);
        check("reg_low", gate_out.regulator_low, !o[3]);
        check("wdt_en", gate_out.watchdog_clk_en, !s);
        osc_in = ~o;
        @(negedge clk_in);
        check("hold_kept", osc_hold_out, o | 4'h1);
    endtask
    task automatic wake(input logic a, input int lo, input int hi);
        int n;
        n = 0;
        irq_accept_en_in = a;
        raise = 1'h1;
        while (vector_go_out !== 1'h1 && resume_go_out !== 1'h1 && n < 60) begin
            @(negedge clk_in);
            n++;
        end
        raise = 1'h0;
        check("vec_go", vector_go_out, a);
        check("resume_go", resume_go_out, !a);
        check("wait_ok", n >= lo && n <= hi, 4'h1);
        @(negedge clk_in);
        check("released", {halted_out, gate_out.cpu_clk_en}, 4'h1);
    endtask
    task automatic reset_sources();
        for (int i = 0; i < 4; i++) begin
            halt_entry(4'h0, 1'h0);
            rst_src_in = hsc_rst_src_t'(4'h1 << i);
            @(negedge clk_in);
            check("reset_hit", {cpu_reset_out, halted_out}, 4'h2);
            rst_src_in = 4'h0;
            repeat (2) @(negedge clk_in);
            check("reset_gone", cpu_reset_out, 4'h0);
        end
    endtask
    task automatic adc_gate();
        periph_clk_run_in = 1'h0;
        repeat (2) @(negedge clk_in);
        check("adc_off", gate_out.adc_en, 4'h0);
        periph_clk_run_in = 1'h1;
        repeat (2) @(negedge clk_in);
        check("adc_on", gate_out.adc_en, 4'h1);
    endtask
    initial begin
        repeat (12) @(negedge clk_in);
        rst_in = 1'h0;
        @(negedge clk_in);
        halt_entry(4'ha, 1'h1);
        wake(1'h1, 26, 40);
        halt_entry(4'h4, 1'h0);
        wake(1'h0, 4, 16);
        reset_sources();
        adc_gate();
        report_and_stop();
    end
    initial begin
        #4000;
        fail_count++;
        report_and_stop();
    end
endmodule
